// ==== src/rsr_pkg.sv ====
// constants and types for the reset source and memory remap block
`default_nettype none

package rsr_pkg;

  // ************************************************
  // register byte addresses
  // ************************************************
  localparam logic [31:0] OFS_MIRROR  = 32'hffff0220;
  localparam logic [31:0] OFS_CAUSE   = 32'hffff0230;
  localparam logic [31:0] OFS_CLR     = 32'hffff0234;
  localparam logic [31:0] OFS_KEY1    = 32'hffff0248;
  localparam logic [31:0] OFS_CFG     = 32'hffff024c;
  localparam logic [31:0] OFS_KEY2    = 32'hffff0250;
  localparam logic [31:0] OFS_IRQ_STA = 32'hffff0260;
  localparam logic [31:0] OFS_IRQ_MSK = 32'hffff0264;

  // ************************************************
  // field positions
  // ************************************************
  localparam int MIR_REMAP       = 0;
  localparam int MIR_SRAM_SMALL  = 3;
  localparam int MIR_FLASH_SMALL = 4;
  localparam int CAUSE_POR       = 0;
  localparam int CAUSE_WDT       = 1;
  localparam int CAUSE_SW        = 2;
  localparam int CFG_GPIO        = 0;
  localparam int CFG_DAC         = 2;
  localparam int IRQ_WDT         = 0;
  localparam int IRQ_SW          = 1;
  localparam int IRQ_EXT         = 2;
  localparam int IRQ_KEYERR      = 3;
  localparam int IRQ_W           = 4;

  // ************************************************
  // values after reset, masks and codes
  // ************************************************
  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [7:0] CAUSE_RST  = 8'h01;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] CAUSE_MASK = 8'h07;
  localparam logic [7:0] CFG_MASK   = 8'h05;
  localparam logic [7:0] KEY1_CODE  = 8'h76;
  localparam logic [7:0] KEY2_CODE  = 8'hb1;
  localparam logic [1:0] DBG_JTAG   = 2'h0;
  localparam logic [1:0] DBG_GPIO   = 2'h3;
  localparam logic [1:0] PIN_RST    = 2'h3;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_NS       = 10;
  localparam int RST_HOLD_NS  = 100;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CNT_W    = 4;
  localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_HOLD_CYC);

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {KEY_IDLE, KEY_OPEN, KEY_STAGED} rsr_key_t;

  typedef struct packed {
    logic sys;
    logic gpio;
    logic dac;
  } rsr_rst_t;

  typedef struct packed {
    logic       jtagEn;
    logic [2:0] pinGpio;
  } rsr_dbg_t;

endpackage

`default_nettype wire

// ==== src/rsr_reset_remap.sv ====
// reset source recording, memory remap and retention control block
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - remap bit set maps SRAM at zero
// - any reset clears the remap bit
// - bit 4 reads one for small flash
// - bit 3 reads one for small SRAM
// - debug field loads 11 when strap conditions hold
// - field 00: pins are JTAG, third disables
// - field 1x: pins GPIO, use disables JTAG
// - four reset kinds, null cause means external
// - writing cause bit 2 forces software reset
// - watchdog reset sets cause bit 1
// - power-on sets cause bit 0, value 0x01
// - cause bits cleared only via clear register
// - config bit 2 keeps DAC through watchdog and software resets
// - config bit 0 keeps GPIO through watchdog and software resets
// - boot pin high at reset selects normal mode

module rsr_reset_remap #(
  parameter bit FLASH_SMALL = 1'b0,
  parameter bit SRAM_SMALL  = 1'b0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // avalon-mm slave
  input  wire logic [31:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // reset sources
  input  wire logic             wdtTimeout,
  input  wire logic             extRstPin_b,
  // boot straps
  input  wire logic             bootModePin,
  input  wire logic             flashCfgBlank,
  // shared debug pins
  input  wire logic [2:0]       gpioUse,
  output var rsr_pkg::rsr_dbg_t dbgPins,
  // system side
  output logic                  remapSram,
  output logic                  normalBoot,
  output var rsr_pkg::rsr_rst_t rstOut,
  output logic                  gpioRetain,
  output logic                  dacRetain,
  output logic                  irq
);

  // ************************************************
  // declarations
  // ************************************************
  logic                            ackQ;
  logic                            wrAcc;
  logic                            rdReq;
  logic [7:0]                      wb;
  logic                            hitMir;
  logic                            hitCause;
  logic                            hitClr;
  logic                            hitKey1;
  logic                            hitCfg;
  logic                            hitKey2;
  logic                            hitIrqSta;
  logic                            hitIrqMsk;
  logic [31:0]                     readdata_q;
  logic [31:0]                     readdata_d;
  logic [1:0]                      pinIn;
  logic [1:0]                      pinLvl;
  logic [1:0]                      pinFall;
  logic                            extEvt;
  logic                            swEvt;
  logic                            anyEvt;
  logic [rsr_pkg::RST_CNT_W-1:0]   rstCnt_q;
  logic                            resetting;
  logic                            bootEnd;
  logic                            keepGpio_q;
  logic                            keepDac_q;
  logic                            remap_q;
  logic [1:0]                      dbgCfg_q;
  logic                            normalBoot_q;
  logic                            jtagLost_q;
  rsr_pkg::rsr_dbg_t               dbgPins_q;
  logic [7:0]                      cause_q;
  logic [7:0]                      causeSet;
  logic [7:0]                      causeClr;
  logic [7:0]                      cfg_q;
  logic [7:0]                      staged_q;
  rsr_pkg::rsr_key_t               keyState_q;
  logic                            keyWr;
  logic                            keyErr;
  logic                            commit;
  logic [rsr_pkg::IRQ_W-1:0]       irqSta_q;
  logic [rsr_pkg::IRQ_W-1:0]       irqMsk_q;
  logic [rsr_pkg::IRQ_W-1:0]       irqEvt;

  // ************************************************
  // avalon slave: one wait state on every access
  // ************************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
  assign wrAcc = avs_write & ackQ & avs_byteenable[0];
  assign rdReq = avs_read & ~ackQ;
  assign wb = avs_writedata[7:0];

  assign hitMir    = avs_address == rsr_pkg::OFS_MIRROR;
  assign hitCause  = avs_address == rsr_pkg::OFS_CAUSE;
  assign hitClr    = avs_address == rsr_pkg::OFS_CLR;
  assign hitKey1   = avs_address == rsr_pkg::OFS_KEY1;
  assign hitCfg    = avs_address == rsr_pkg::OFS_CFG;
  assign hitKey2   = avs_address == rsr_pkg::OFS_KEY2;
  assign hitIrqSta = avs_address == rsr_pkg::OFS_IRQ_STA;
  assign hitIrqMsk = avs_address == rsr_pkg::OFS_IRQ_MSK;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avs_read | avs_write) & ~ackQ;
    end
  end

  // read data is captured in the wait cycle so it stands steady at the answer
  always_comb begin
    readdata_d = '0;
    if (hitMir) begin
      readdata_d[rsr_pkg::MIR_REMAP] = remap_q;
      readdata_d[2:1] = dbgCfg_q;
      readdata_d[rsr_pkg::MIR_SRAM_SMALL] = SRAM_SMALL;
      readdata_d[rsr_pkg::MIR_FLASH_SMALL] = FLASH_SMALL;
    end else if (hitCause) begin
      readdata_d[7:0] = cause_q;
    end else if (hitCfg) begin
      readdata_d[7:0] = cfg_q;
    end else if (hitIrqSta) begin
      readdata_d[rsr_pkg::IRQ_W-1:0] = irqSta_q;
    end else if (hitIrqMsk) begin
      readdata_d[rsr_pkg::IRQ_W-1:0] = irqMsk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readdata_q <= '0;
    end else if (rdReq) begin
      readdata_q <= readdata_d;
    end
  end

  assign avs_readdata = readdata_q;

  // ************************************************
  // pin synchronisers with agreement filter
  // ************************************************
  assign pinIn = {bootModePin, extRstPin_b};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic [2:0] sh;
    logic       lvl;
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        sh  <= 3'h7;
        lvl <= rsr_pkg::PIN_RST[i];
      end else begin
        sh <= {sh[1:0], pinIn[i]};
        if (sh[2] == sh[1]) begin
          lvl <= sh[2];
        end
      end
    end
    assign pinLvl[i] = lvl;
    assign pinFall[i] = (sh[2] == sh[1]) & ~sh[2] & lvl;
  end

  // ************************************************
  // reset sequencing
  // ************************************************
  assign extEvt = pinFall[0];
  assign swEvt = wrAcc & hitCause & wb[rsr_pkg::CAUSE_SW];
  assign anyEvt = wdtTimeout | swEvt | extEvt;
  assign resetting = rstCnt_q != '0;
  assign bootEnd = rstCnt_q == rsr_pkg::RST_CNT_W'(1);

  // power-on also runs one full sequence so the straps get sampled at its end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rstCnt_q <= rsr_pkg::RST_LOAD;
    end else if (anyEvt) begin
      rstCnt_q <= rsr_pkg::RST_LOAD;
    end else if (resetting) begin
      rstCnt_q <= rstCnt_q - rsr_pkg::RST_CNT_W'(1);
    end
  end

  // external reset never retains, whatever the configuration says
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keepGpio_q <= 1'b0;
      keepDac_q  <= 1'b0;
    end else if (anyEvt) begin
      keepGpio_q <= cfg_q[rsr_pkg::CFG_GPIO] & ~extEvt;
      keepDac_q  <= cfg_q[rsr_pkg::CFG_DAC] & ~extEvt;
    end
  end

  assign rstOut.sys  = resetting;
  assign rstOut.gpio = resetting & ~keepGpio_q;
  assign rstOut.dac  = resetting & ~keepDac_q;
  assign gpioRetain  = cfg_q[rsr_pkg::CFG_GPIO];
  assign dacRetain   = cfg_q[rsr_pkg::CFG_DAC];

  // ************************************************
  // memory remap and boot straps
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      remap_q <= rsr_pkg::MIRROR_RST[rsr_pkg::MIR_REMAP];
    end else if (resetting || anyEvt) begin
      remap_q <= 1'b0;
    end else if (wrAcc && hitMir) begin
      remap_q <= wb[rsr_pkg::MIR_REMAP];
    end
  end

  assign remapSram = remap_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dbgCfg_q     <= rsr_pkg::MIRROR_RST[2:1];
      normalBoot_q <= 1'b1;
    end else if (bootEnd) begin
      dbgCfg_q <= (!pinLvl[1] && !flashCfgBlank) ? rsr_pkg::DBG_GPIO
                                                 : rsr_pkg::DBG_JTAG;
      normalBoot_q <= pinLvl[1];
    end
  end

  assign normalBoot = normalBoot_q;

  // ************************************************
  // shared debug pins
  // ************************************************
  // losing jtag is sticky until the next reset; a probe cannot win it back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      jtagLost_q <= 1'b0;
    end else if (resetting) begin
      jtagLost_q <= 1'b0;
    end else if (dbgCfg_q[1] ? |gpioUse : gpioUse[2]) begin
      jtagLost_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dbgPins_q <= '0;
    end else begin
      dbgPins_q.jtagEn <= ~jtagLost_q;
      if (dbgCfg_q[1]) begin
        dbgPins_q.pinGpio <= 3'h7;
      end else begin
        dbgPins_q.pinGpio <= {gpioUse[2], 2'h0};
      end
    end
  end

  assign dbgPins = dbgPins_q;

  // ************************************************
  // reset cause register
  // ************************************************
  always_comb begin
    causeSet = '0;
    causeSet[rsr_pkg::CAUSE_WDT] = wdtTimeout;
    causeSet[rsr_pkg::CAUSE_SW] = swEvt;
    causeClr = (wrAcc && hitClr) ? (wb & rsr_pkg::CAUSE_MASK) : 8'h00;
  end

  // a new cause wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cause_q <= rsr_pkg::CAUSE_RST;
    end else begin
      cause_q <= (cause_q & ~causeClr) | causeSet;
    end
  end

  // ************************************************
  // keyed retention configuration
  // ************************************************
  assign keyWr = wrAcc & (hitKey1 | hitCfg | hitKey2);

  always_comb begin
    keyErr = 1'b0;
    commit = 1'b0;
    unique case (keyState_q)
      rsr_pkg::KEY_IDLE:
        keyErr = keyWr & ~(hitKey1 & (wb == rsr_pkg::KEY1_CODE));
      rsr_pkg::KEY_OPEN:
        keyErr = keyWr & ~hitCfg;
      rsr_pkg::KEY_STAGED: begin
        commit = keyWr & hitKey2 & (wb == rsr_pkg::KEY2_CODE);
        keyErr = keyWr & ~commit;
      end
      default: keyErr = keyWr;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keyState_q <= rsr_pkg::KEY_IDLE;
      staged_q   <= rsr_pkg::CFG_RST;
    end else if (anyEvt || keyErr || commit) begin
      keyState_q <= rsr_pkg::KEY_IDLE;
    end else if (keyWr && keyState_q == rsr_pkg::KEY_IDLE) begin
      keyState_q <= rsr_pkg::KEY_OPEN;
    end else if (keyWr && keyState_q == rsr_pkg::KEY_OPEN) begin
      keyState_q <= rsr_pkg::KEY_STAGED;
      staged_q   <= wb;
    end
  end

  // reserved bits are forced low in case software breaks the convention
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_q <= rsr_pkg::CFG_RST;
    end else if (extEvt) begin
      cfg_q <= rsr_pkg::CFG_RST;
    end else if (commit) begin
      cfg_q <= staged_q & rsr_pkg::CFG_MASK;
    end
  end

  // ************************************************
  // interrupt status and mask
  // ************************************************
  always_comb begin
    irqEvt = '0;
    irqEvt[rsr_pkg::IRQ_WDT] = wdtTimeout;
    irqEvt[rsr_pkg::IRQ_SW] = swEvt;
    irqEvt[rsr_pkg::IRQ_EXT] = extEvt;
    irqEvt[rsr_pkg::IRQ_KEYERR] = keyErr;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqSta_q <= '0;
    end else if (wrAcc && hitIrqSta) begin
      irqSta_q <= (irqSta_q & ~wb[rsr_pkg::IRQ_W-1:0]) | irqEvt;
    end else begin
      irqSta_q <= irqSta_q | irqEvt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqMsk_q <= '0;
    end else if (wrAcc && hitIrqMsk) begin
      irqMsk_q <= wb[rsr_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irqSta_q & irqMsk_q);

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_remap_set: assert property (
    wrAcc && hitMir && wb[0] && !resetting && !anyEvt |=> remapSram)
    else $error("remap bit write did not map sram");

  a_remap_clear: assert property (resetting |=> !remapSram)
    else $error("remap survived a reset");

  a_flash_size: assert property (
    avs_read && !avs_waitrequest && hitMir |-> avs_readdata[4] == FLASH_SMALL)
    else $error("flash size bit wrong");

  a_sram_size: assert property (
    avs_read && !avs_waitrequest && hitMir |-> avs_readdata[3] == SRAM_SMALL)
    else $error("sram size bit wrong");

  a_dbg_load: assert property (
    bootEnd && !pinLvl[1] && !flashCfgBlank |=> dbgCfg_q == 2'h3)
    else $error("debug field not loaded with 11");

  a_jtag_lock: assert property (
    dbgCfg_q == 2'h0 && gpioUse[2] && !resetting |=> ##1 !dbgPins.jtagEn)
    else $error("jtag still enabled after third pin used");

  a_gpio_jtag: assert property (
    dbgCfg_q[1] && |gpioUse && !resetting |=> ##1 !dbgPins.jtagEn && dbgPins.pinGpio == 3'h7)
    else $error("gpio use did not disable jtag");

  a_ext_reset: assert property (
    extEvt |=> rstOut.sys && rstOut.gpio && rstOut.dac)
    else $error("external reset not full");

  a_sw_cause: assert property (swEvt |=> cause_q[2] && rstOut.sys)
    else $error("software reset not forced or recorded");

  a_wdt_cause: assert property (wdtTimeout |=> cause_q[1] && rstOut.sys)
    else $error("watchdog cause not recorded");

  a_por_cause: assert property ($rose(rst_b) |-> cause_q[0])
    else $error("power-on cause missing");

  a_cause_clear: assert property (
    $fell(cause_q[1]) |-> $past(wrAcc && hitClr && wb[1]))
    else $error("cause bit dropped without clear write");

  a_dac_keep: assert property (
    wdtTimeout && !extEvt && cfg_q[2] |=> rstOut.sys && !rstOut.dac)
    else $error("dac reset despite retention");

  a_gpio_keep: assert property (
    swEvt && !extEvt && cfg_q[0] |=> rstOut.sys && !rstOut.gpio)
    else $error("gpio reset despite retention");

  a_boot_mode: assert property (bootEnd |=> normalBoot == $past(pinLvl[1]))
    else $error("boot mode not captured");

  a_key_order: assert property (
    $changed(cfg_q) |-> $past(commit) || $past(extEvt))
    else $error("config changed without key sequence");

endmodule // rsr_reset_remap

`default_nettype wire

// ==== testbench/rsr_tb.sv ====
// self-checking testbench for the reset source and memory remap block
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ************************************************
  // signals
  // ************************************************
  logic              clk;
  logic              rst_b;
  logic [31:0]       avsAddress;
  logic              avsRead;
  logic              avsWrite;
  logic [31:0]       avsWritedata;
  logic [31:0]       avsReaddata;
  logic              avsWaitrequest;
  logic              wdtTimeout;
  logic              extRstPin_b;
  logic              bootModePin;
  logic              flashCfgBlank;
  logic [2:0]        gpioUse;
  rsr_pkg::rsr_dbg_t dbgPins;
  logic              remapSram;
  logic              normalBoot;
  rsr_pkg::rsr_rst_t rstOut;
  logic              gpioRetain;
  logic              dacRetain;
  logic              irq;
  int                mismatches;
  int                checks_done;
  logic [31:0]       rdv;

  // both size flags set so the read-only bits are seen high
  localparam logic [7:0] SIZE_BITS = 8'h18;

  rsr_reset_remap #(.FLASH_SMALL(1'b1), .SRAM_SMALL(1'b1)) dut (
    .clk(clk), .rst_b(rst_b),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(4'h1),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .wdtTimeout(wdtTimeout), .extRstPin_b(extRstPin_b),
    .bootModePin(bootModePin), .flashCfgBlank(flashCfgBlank),
    .gpioUse(gpioUse), .dbgPins(dbgPins), .remapSram(remapSram),
    .normalBoot(normalBoot), .rstOut(rstOut), .gpioRetain(gpioRetain),
    .dacRetain(dacRetain), .irq(irq)
  );

  // ************************************************
  // clock and watchdog
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one avalon transfer; an idle cycle follows so requests never collide
  task automatic busOp(input logic isWr, input logic [31:0] addr, input logic [7:0] wd);
    int n;
    n = 0;
    avsAddress <= addr;
    avsWritedata <= {24'h0, wd};
    avsWrite <= isWr;
    avsRead <= !isWr;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
    rdv = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [7:0] wd);
    busOp(1'b1, addr, wd);
  endtask

  task automatic rdchk(input string nm, input logic [31:0] addr, input logic [7:0] exp);
    busOp(1'b0, addr, 8'h00);
    chk(nm, {24'h0, exp}, rdv);
  endtask

  task automatic unlock(input logic [7:0] val);
    wr(rsr_pkg::OFS_KEY1, 8'h76);
    wr(rsr_pkg::OFS_CFG, val);
    wr(rsr_pkg::OFS_KEY2, 8'hb1);
  endtask

  // waits for a reset sequence to start and to finish, both bounded
  task automatic waitSys();
    int n;
    n = 0;
    while (rstOut.sys !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (rstOut.sys !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) chk("reset sequence", 32'h0, 32'h1);
    @(posedge clk);
  endtask

  task automatic extReset();
    repeat (4) @(posedge clk);
    extRstPin_b <= 1'b0;
    repeat (6) @(posedge clk);
    extRstPin_b <= 1'b1;
    waitSys();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    mismatches = 0;
    checks_done = 0;
    rst_b = 1'b0;
    avsAddress = 32'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    wdtTimeout = 1'b0;
    extRstPin_b = 1'b1;
    bootModePin = 1'b1;
    flashCfgBlank = 1'b0;
    gpioUse = 3'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    waitSys();
    // values after power-on, unmapped place, normal boot
    rdchk("mirror rst", rsr_pkg::OFS_MIRROR, SIZE_BITS);
    rdchk("cause rst", rsr_pkg::OFS_CAUSE, 8'h01);
    rdchk("cfg rst", rsr_pkg::OFS_CFG, 8'h00);
    rdchk("clear reg", rsr_pkg::OFS_CLR, 8'h00);
    wr(32'hffff0300, 8'hff);
    rdchk("unmapped", 32'hffff0300, 8'h00);
    chk("normalBoot", 32'h1, {31'h0, normalBoot});
    chk("dbg 00", 32'h8, {28'h0, dbgPins});
    // field 00: pins a,b stay debug, pin c as gpio kills jtag
    gpioUse <= 3'b011;
    repeat (3) @(posedge clk);
    chk("dbg ab", 32'h8, {28'h0, dbgPins});
    gpioUse <= 3'b100;
    repeat (3) @(posedge clk);
    chk("dbg c", 32'h4, {28'h0, dbgPins});
    gpioUse <= 3'h0;
    // remap, read-only bits ignore writes
    wr(rsr_pkg::OFS_MIRROR, 8'hff);
    rdchk("mirror set", rsr_pkg::OFS_MIRROR, SIZE_BITS | 8'h01);
    chk("remapSram", 32'h1, {31'h0, remapSram});
    // config write without keys is dropped and flags a key error
    wr(rsr_pkg::OFS_CFG, 8'h05);
    rdchk("cfg nokey", rsr_pkg::OFS_CFG, 8'h00);
    rdchk("irq sta", rsr_pkg::OFS_IRQ_STA, 8'h08);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(rsr_pkg::OFS_IRQ_MSK, 8'h08);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(rsr_pkg::OFS_IRQ_STA, 8'h08);
    chk("irq off", 32'h0, {31'h0, irq});
    rdchk("irq sta clr", rsr_pkg::OFS_IRQ_STA, 8'h00);
    // keyed write, reserved bits kept at zero by software
    unlock(8'h05);
    rdchk("cfg keyed", rsr_pkg::OFS_CFG, 8'h05);
    chk("retain", 32'h3, {30'h0, gpioRetain, dacRetain});
    // watchdog reset with both retained
    wdtTimeout <= 1'b1;
    @(posedge clk);
    wdtTimeout <= 1'b0;
    @(negedge clk);
    chk("rst wdt", 32'h4, {29'h0, rstOut});
    waitSys();
    rdchk("cause wdt", rsr_pkg::OFS_CAUSE, 8'h03);
    rdchk("mirror wdt", rsr_pkg::OFS_MIRROR, SIZE_BITS);
    chk("remap wdt", 32'h0, {31'h0, remapSram});
    rdchk("cfg kept", rsr_pkg::OFS_CFG, 8'h05);
    chk("irq mask wdt", 32'h0, {31'h0, irq});
    // cause clearing only through the clear register
    wr(rsr_pkg::OFS_CLR, 8'h02);
    rdchk("cause clr1", rsr_pkg::OFS_CAUSE, 8'h01);
    wr(rsr_pkg::OFS_CAUSE, 8'h00);
    rdchk("cause w0", rsr_pkg::OFS_CAUSE, 8'h01);
    wr(rsr_pkg::OFS_CLR, 8'h07);
    rdchk("cause clr all", rsr_pkg::OFS_CAUSE, 8'h00);
    // software reset keeping gpio only
    unlock(8'h01);
    wr(rsr_pkg::OFS_CAUSE, 8'h04);
    @(negedge clk);
    chk("rst sw", 32'h5, {29'h0, rstOut});
    waitSys();
    rdchk("cause sw", rsr_pkg::OFS_CAUSE, 8'h04);
    // external reset with straps for gpio mode
    wr(rsr_pkg::OFS_CLR, 8'h07);
    wr(rsr_pkg::OFS_MIRROR, 8'h01);
    bootModePin <= 1'b0;
    extReset();
    rdchk("cause ext", rsr_pkg::OFS_CAUSE, 8'h00);
    rdchk("cfg ext", rsr_pkg::OFS_CFG, 8'h00);
    rdchk("mirror 11", rsr_pkg::OFS_MIRROR, SIZE_BITS | 8'h06);
    chk("normalBoot low", 32'h0, {31'h0, normalBoot});
    chk("dbg 1x", 32'hf, {28'h0, dbgPins});
    gpioUse <= 3'b010;
    repeat (3) @(posedge clk);
    chk("dbg 1x used", 32'h7, {28'h0, dbgPins});
    gpioUse <= 3'h0;
    // blank configuration word leaves the field at 00
    flashCfgBlank <= 1'b1;
    extReset();
    rdchk("mirror blank", rsr_pkg::OFS_MIRROR, SIZE_BITS);
    summarize();
  end
endmodule // tb

`default_nettype wire
